// *** shared/tmc_defines.svh ***
// Register indices, field positions, reset values and timing figures of the temperature control.
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// Avalon byte address width; the word index is address bits [17:2].
`define TMC_ADDR_W 18
`define TMC_IDX_W 16

// Register indices; the byte address of each is four times its index.
`define TMC_IDX_REF_HI 16'h230A
`define TMC_IDX_REF_LO 16'h230B
`define TMC_IDX_RES_HI 16'h2881
`define TMC_IDX_RES_LO 16'h2882
`define TMC_IDX_CFG 16'h28A0
`define TMC_IDX_TRIG 16'h28B4

// Fields of the configuration byte.
`define TMC_CFG_PER_MSB 2
`define TMC_CFG_PER_LSB 0
`define TMC_CFG_BUSY_BIT 3
`define TMC_CFG_BAT_BIT 4
`define TMC_CFG_PWR_BIT 6
`define TMC_CFG_WMASK 8'hD7
`define TMC_CFG_RST 8'h00

// One-shot trigger bit in its own byte.
`define TMC_TRIG_BIT 6

// Period field codes and the exponent base of the period.
`define TMC_PER_OFF 3'h0
`define TMC_PER_CONT 3'h7
`define TMC_PER_EXP_BASE 3

// Result and reference word layout.
`define TMC_RES_W 11
`define TMC_RES_LO_BITS 3
`define TMC_REF_LO_BITS 8
`define TMC_READ_ZERO 32'h0000_0000

// Timing: clock rate, longest commit time and one second.
`define TMC_CLK_MHZ 50
`define TMC_COMMIT_TIME_US 6000
`define TMC_SECOND_US 1000000
`define TMC_COMMIT_CYCLES (`TMC_COMMIT_TIME_US * `TMC_CLK_MHZ)
`define TMC_SECOND_CYCLES (`TMC_SECOND_US * `TMC_CLK_MHZ)

`endif

// *** shared/tmc_pkg.sv ***
// Types shared by the temperature measurement control.
`default_nettype none
package tmc_pkg;
	// Measurement sequencer states.
	typedef enum logic [0:0]
	{
		TMC_ST_IDLE = 1'b0,
		TMC_ST_MEAS = 1'b1
	} tmc_state_t;
endpackage
`default_nettype wire

// *** hw/tmc_top.sv ***
// Temperature measurement sequencer with its Avalon-MM register file.
// Every commit waits out the full worst-case time, so a config write
// shows in readback only once that time has passed; the busy bit tells
// software when. The reference word is not held here: it follows its
// input one cycle late, since the factory value is kept elsewhere.
`timescale 1ns/10ps
`include "tmc_defines.svh"
`default_nettype none

module tmc_top
	import tmc_pkg::*;
#(
	parameter int unsigned COMMIT_CYCLES = `TMC_COMMIT_CYCLES,
	parameter int unsigned SECOND_CYCLES = `TMC_SECOND_CYCLES
)
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [`TMC_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic sleep_state_i,
	input wire logic meas_done_i,
	input wire logic [`TMC_RES_W-1:0] meas_result_i,
	input wire logic [`TMC_RES_W-1:0] ref_temp_i,
	output logic meas_start_o,
	output logic meas_battery_o,
	output logic sensor_on_main_o
);

	// Counter widths follow the parameters so a short simulation value shrinks them too.
	localparam int CW = $clog2(COMMIT_CYCLES + 1);
	localparam int SW = $clog2(SECOND_CYCLES + 1);

	// The counters cannot serve a zero commit time or a divider below two.
	if (COMMIT_CYCLES < 1 || SECOND_CYCLES < 2)
	begin : g_bad_params
		$error("tmc_top: COMMIT_CYCLES must be >= 1 and SECOND_CYCLES >= 2.");
	end

	// All state of the block in one record.
	typedef struct packed {
		logic [2:0] sync; // Sleep pin synchroniser, oldest stage on top.
		logic sleep; // Filtered sleep state.
		logic waitreq; // Avalon waitrequest.
		logic [31:0] rdata; // Avalon read data.
		logic [7:0] cfg; // Committed configuration byte.
		logic [7:0] staged; // Value being committed.
		logic busy; // Commit in progress.
		logic [CW-1:0] commit_cnt; // Cycles spent committing.
		logic [SW-1:0] sec_div; // One-second divider.
		logic [9:0] period_cnt; // Seconds since the last periodic start.
		logic auto_req; // Periodic measurement due.
		logic trigger; // One-shot trigger bit.
		tmc_state_t state; // Sequencer state.
		logic start; // Start pulse to the converter.
		logic bat; // Battery measurement with this run.
		logic on_main; // Sensor supplied from the main supply.
		logic [`TMC_RES_W-1:0] result; // Last temperature result.
		logic [`TMC_RES_W-1:0] ref_val; // Stored 22 C reference.
	} tmc_regs_t;

	// Reset image: bus stalls, sequencer idle, everything else clear.
	localparam tmc_regs_t REGS_RST = '{waitreq: 1'b1, state: TMC_ST_IDLE, default: '0};

	tmc_regs_t r; // Registered state.
	tmc_regs_t n; // Next state.
	logic sec_tick; // One-cycle enable once per second.
	logic req; // A bus request is present.
	logic [`TMC_IDX_W-1:0] idx; // Word index of the request.
	logic [2:0] per; // Committed period field.

	// Period in seconds for codes one to six.
	function automatic logic [9:0] period_secs(input logic [2:0] code);
		period_secs = 10'(1) << (`TMC_PER_EXP_BASE + 32'(code));
	endfunction

	// Read value of one register; unmapped indices read as zero.
	function automatic logic [31:0] read_mux(input logic [`TMC_IDX_W-1:0] i,
		input tmc_regs_t s);
		read_mux = `TMC_READ_ZERO;
		case (i)
			`TMC_IDX_REF_HI: read_mux[2:0] = s.ref_val[`TMC_RES_W-1:`TMC_REF_LO_BITS];
			`TMC_IDX_REF_LO: read_mux[7:0] = s.ref_val[`TMC_REF_LO_BITS-1:0];
			`TMC_IDX_RES_HI: read_mux[7:0] = s.result[`TMC_RES_W-1:`TMC_RES_LO_BITS];
			`TMC_IDX_RES_LO: read_mux[7:5] = s.result[`TMC_RES_LO_BITS-1:0];
			`TMC_IDX_CFG:
			begin
				read_mux[7:0] = s.cfg;
				read_mux[`TMC_CFG_BUSY_BIT] = s.busy;
			end
			`TMC_IDX_TRIG: read_mux[`TMC_TRIG_BIT] = s.trigger;
			default: read_mux = `TMC_READ_ZERO;
		endcase
	endfunction

	// Next-state logic. Later sections override earlier ones, so a set placed
	// after a clear wins when both land in the same cycle.
	always_comb
	begin
		n = r;
		req = avs_read_i | avs_write_i;
		idx = avs_address_i[`TMC_ADDR_W-1:2];
		per = r.cfg[`TMC_CFG_PER_MSB:`TMC_CFG_PER_LSB];
		n.start = 1'b0;

		// The sleep pin is asynchronous; a change counts once stages two and three agree.
		// The first stage feeds only the second, so its settling time is never seen.
		n.sync = {r.sync[1:0], sleep_state_i};
		if (r.sync[1] == r.sync[2])
		begin
			n.sleep = r.sync[2];
		end

		// The reference word is a factory value; it simply follows its source.
		n.ref_val = ref_temp_i;

		// Asleep the supply select is overridden and the battery always feeds the sensor.
		n.on_main = r.cfg[`TMC_CFG_PWR_BIT] & ~r.sleep;

		// Seconds divider.
		sec_tick = (r.sec_div == SW'(SECOND_CYCLES - 1));
		n.sec_div = sec_tick ? '0 : r.sec_div + 1'b1;

		// Sequencer: one measurement at a time, result copied whole on completion.
		case (r.state)
			TMC_ST_IDLE:
			begin
				// Periodic and continuous runs go on in sleep too; the trigger does not.
				if (r.auto_req || per == `TMC_PER_CONT ||
					(r.trigger && per == `TMC_PER_OFF && !r.sleep))
				begin
					n.start = 1'b1;
					n.bat = r.cfg[`TMC_CFG_BAT_BIT];
					n.auto_req = 1'b0;
					n.state = TMC_ST_MEAS;
				end
			end
			TMC_ST_MEAS:
			begin
				if (meas_done_i)
				begin
					n.result = meas_result_i;
					n.trigger = 1'b0;
					n.state = TMC_ST_IDLE;
				end
			end
			default: n.state = TMC_ST_IDLE;
		endcase

		// Period timer; a due run waits in auto_req while a measurement is busy.
		// The count restarts with each commit, but the seconds divider runs on, so a new
		// period is measured from the last tick before it takes effect, not from the commit.
		if (per == `TMC_PER_OFF || per == `TMC_PER_CONT)
		begin
			n.period_cnt = '0;
		end
		else if (sec_tick)
		begin
			if (r.period_cnt + 10'd1 >= period_secs(per))
			begin
				n.period_cnt = '0;
				n.auto_req = 1'b1;
			end
			else
			begin
				n.period_cnt = r.period_cnt + 10'd1;
			end
		end

		// Slow commit of the configuration byte; the new period restarts the timer.
		// Hardware always spends the longest commit time, which keeps the lockout simple.
		if (r.busy)
		begin
			if (r.commit_cnt == CW'(COMMIT_CYCLES - 1))
			begin
				n.busy = 1'b0;
				n.cfg = r.staged;
				n.period_cnt = '0;
				n.auto_req = 1'b0;
			end
			else
			begin
				n.commit_cnt = r.commit_cnt + 1'b1;
			end
		end

		// Avalon slave: one wait cycle, then the access completes at the edge
		// where waitrequest is low.
		// Read data are taken at the first edge and stand until the next access.
		if (req && r.waitreq)
		begin
			n.waitreq = 1'b0;
			n.rdata = read_mux(idx, r);
		end
		else if (req)
		begin
			n.waitreq = 1'b1;
			if (avs_write_i && avs_byteenable_i[0])
			begin
				// A config write during a commit is dropped, not queued.
				if (idx == `TMC_IDX_CFG && !r.busy)
				begin
					// Busy and the unused bit are read-only; the reserved bit is kept
					// as written, since software keeps it at zero.
					n.staged = avs_writedata_i[7:0] & `TMC_CFG_WMASK;
					n.busy = 1'b1;
					n.commit_cnt = '0;
				end
				// The trigger is taken only with the period off and while awake.
				if (idx == `TMC_IDX_TRIG && avs_writedata_i[`TMC_TRIG_BIT] &&
					per == `TMC_PER_OFF && !r.sleep)
				begin
					n.trigger = 1'b1;
				end
			end
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			r <= REGS_RST;
		end
		else
		begin
			r <= n;
		end
	end

	// Every output is a field of the state record.
	assign avs_readdata_o = r.rdata;
	assign avs_waitrequest_o = r.waitreq;
	assign meas_start_o = r.start;
	assign meas_battery_o = r.bat;
	assign sensor_on_main_o = r.on_main;

	// Helper: an accepted write to the configuration byte.
	logic cfg_wr_done;
	assign cfg_wr_done = avs_write_i && !r.waitreq && avs_byteenable_i[0] &&
		(avs_address_i[`TMC_ADDR_W-1:2] == `TMC_IDX_CFG);

	// An accepted config write raises busy for the whole commit.
	chk_busy_raise: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		cfg_wr_done && !r.busy |=> r.busy && r.commit_cnt == '0)
	else $error("busy flag did not rise on config write");

	// A write during a commit leaves the staged value alone.
	chk_write_locked: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		cfg_wr_done && r.busy |=> $stable(r.staged))
	else $error("config write accepted while busy");

	// The commit never runs past its time and ends by loading the staged byte.
	chk_commit_end: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		r.busy && r.commit_cnt == CW'(COMMIT_CYCLES - 1) |=> !r.busy && r.cfg == $past(r.staged))
	else $error("commit did not finish on time");

	// A due period start reaches the converter two edges later.
	chk_period_start: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		sec_tick && !r.busy && r.state == TMC_ST_IDLE && per != `TMC_PER_OFF &&
		per != `TMC_PER_CONT && r.period_cnt + 10'd1 >= period_secs(per)
		|-> ##2 r.start)
	else $error("periodic measurement not started");

	// Continuous mode restarts as soon as the sequencer is idle.
	chk_continuous: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		r.state == TMC_ST_IDLE && per == `TMC_PER_CONT && !r.busy |=> r.start)
	else $error("continuous measurement not restarted");

	// With the period off, nothing starts without the trigger.
	chk_no_auto: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		per == `TMC_PER_OFF && !r.trigger && !r.auto_req && !r.busy |=> !r.start)
	else $error("measurement started without trigger");

	// The battery flag travels with the start it belongs to.
	chk_bat_follow: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		r.start |-> r.bat == $past(r.cfg[`TMC_CFG_BAT_BIT]))
	else $error("battery option not applied");

	// Awake, the supply output follows the select bit.
	chk_supply_sel: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!r.sleep ##1 !$past(r.sleep) |-> r.on_main == $past(r.cfg[`TMC_CFG_PWR_BIT]))
	else $error("supply select not followed");

	// Asleep, the sensor is never on the main supply.
	chk_sleep_batt: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		r.sleep |=> !r.on_main)
	else $error("main supply used in sleep");

	// Both halves of the result come from one completion.
	chk_result_both: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		r.state == TMC_ST_MEAS && meas_done_i |=> r.result == $past(meas_result_i))
	else $error("result not captured whole");

	// The trigger drops when its measurement completes, unless set again.
	chk_trig_clear: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		r.state == TMC_ST_MEAS && meas_done_i && !avs_write_i |=> !r.trigger)
	else $error("trigger not cleared");

	// The reference register tracks its source one cycle late. It is checked only
	// from an edge outside reset, because the reset image of the register is zero.
	chk_ref_track: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!srst_i |=> r.ref_val == $past(ref_temp_i))
	else $error("reference not tracked");

	// Busy stays high until the commit counter has reached its end.
	chk_busy_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		r.busy && r.commit_cnt != CW'(COMMIT_CYCLES - 1) |=> r.busy)
	else $error("busy flag dropped before commit end");

	// Outside a commit the configuration byte never changes.
	chk_cfg_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!r.busy |=> r.cfg == $past(r.cfg))
	else $error("config byte changed outside a commit");

	// A trigger that is clear while asleep stays clear.
	chk_trig_asleep: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		r.sleep && !r.trigger |=> !r.trigger)
	else $error("trigger set in sleep");

	// A start pulse always belongs to a running measurement, so runs never overlap.
	chk_start_meas: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		r.start |-> r.state == TMC_ST_MEAS)
	else $error("start outside a measurement");

endmodule // tmc_top

`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking testbench for the temperature measurement control.
`timescale 1ns/10ps
`include "tmc_defines.svh"
`default_nettype none

module tb_top;
	// Short commit and second keep the run brief.
	localparam int CC = 20;
	localparam int SC = 10;
	localparam logic [15:0] CFG = `TMC_IDX_CFG;
	localparam logic [15:0] TRIG = `TMC_IDX_TRIG;
	// One table row: register index beside its expected read value.
	typedef struct packed
	{
		logic [15:0] i;
		logic [31:0] e;
	} tmc_row_t;
	tmc_row_t rows [7] = '{'{`TMC_IDX_REF_HI, 32'h0000_0005}, '{`TMC_IDX_REF_LO, 32'h0000_00A3},
		'{`TMC_IDX_RES_HI, 32'h0000_0000}, '{`TMC_IDX_RES_LO, 32'h0000_0000},
		'{CFG, 32'h0000_0000}, '{TRIG, 32'h0000_0000}, '{16'h1234, 32'h0000_0000}};
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic [`TMC_ADDR_W-1:0] adr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] rdat;
	logic wreq;
	logic sleep_state = 1'b0;
	logic done = 1'b0;
	logic [10:0] res = 11'h000;
	logic [31:0] q;
	logic start;
	logic bat;
	logic on_main;
	logic bat_seen = 1'b0;
	int failures = 0;
	int checks_done = 0;
	int starts = 0;
	int cyc = 0;
	int dly = 0;
	int s0 = 0;

	tmc_top #(.COMMIT_CYCLES(CC), .SECOND_CYCLES(SC)) uut
	(
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.avs_address_i(adr),
		.avs_read_i(rd),
		.avs_write_i(wr),
		.avs_writedata_i(wd),
		.avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq),
		.sleep_state_i(sleep_state),
		.meas_done_i(done),
		.meas_result_i(res),
		.ref_temp_i(11'h5A3),
		.meas_start_o(start),
		.meas_battery_o(bat),
		.sensor_on_main_o(on_main)
	);

	// Free-running 50 MHz clock.
	initial
	begin
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	// Converter stand-in: counts starts and answers each three cycles later.
	always @(posedge clk_sys_i)
	begin
		done <= (dly == 1);
		if (start === 1'b1)
		begin
			starts <= starts + 1;
			bat_seen <= bat;
			dly <= 3;
		end
		else if (dly > 0)
			dly <= dly - 1;
	end

	// Hang guard; the whole sequence needs just under eight hundred cycles.
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			failures++;
			$display("[FAIL] %0t timeout", $time);
			results();
		end
	end

	// Compares one value and counts the outcome.
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		checks_done++;
		if (s !== e)
		begin
			failures++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, s, e);
		end
	endtask

	// One Avalon access; holds the request until waitrequest is seen low.
	task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d);
		adr <= {i, 2'b00};
		rd <= ~w;
		wr <= w;
		wd <= {24'h000000, d};
		do @(posedge clk_sys_i); while (wreq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	task automatic rdchk(input logic [15:0] i, input logic [31:0] e, input string m);
		bus(1'b0, i, 8'h00);
		chk(q, e, m);
	endtask

	// Waits out a whole configuration commit plus margin.
	task automatic commit();
		repeat (CC + 5) @(posedge clk_sys_i);
	endtask

	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Main sequence.
	initial
	begin
		repeat (6) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		@(posedge clk_sys_i);
		foreach (rows[k])
			rdchk(rows[k].i, rows[k].e, "reset table");
		$display("test reset table done");
		// The second write lands while busy and must be lost.
		bus(1'b1, CFG, 8'h50);
		rdchk(CFG, 32'h0000_0008, "busy during commit");
		bus(1'b1, CFG, 8'h03);
		commit();
		rdchk(CFG, 32'h0000_0050, "committed value");
		chk({31'h0, on_main}, 32'h1, "main supply");
		$display("test commit done");
		res <= 11'h6B5;
		s0 = starts;
		bus(1'b1, TRIG, 8'h40);
		repeat (10) @(posedge clk_sys_i);
		chk(32'(starts - s0), 32'h1, "one shot");
		chk({31'h0, bat_seen}, 32'h1, "battery run");
		rdchk(`TMC_IDX_RES_HI, 32'h0000_00D6, "result high");
		rdchk(`TMC_IDX_RES_LO, 32'h0000_00A0, "result low");
		rdchk(TRIG, 32'h0000_0000, "trigger cleared");
		$display("test one shot done");
		// Asleep the supply select is overridden and the trigger refused.
		// Three synchroniser stages, the filter and the supply register: five edges; six are waited.
		sleep_state <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		chk({31'h0, on_main}, 32'h0, "sleep supply");
		s0 = starts;
		bus(1'b1, TRIG, 8'h40);
		repeat (10) @(posedge clk_sys_i);
		chk(32'(starts - s0), 32'h0, "trigger asleep");
		// Period code 1 gives one run every sixteen seconds, also asleep.
		bus(1'b1, CFG, 8'h51);
		commit();
		s0 = starts;
		repeat (330) @(posedge clk_sys_i);
		chk(32'(starts - s0), 32'h2, "period one");
		$display("test sleep periodic done");
		sleep_state <= 1'b0;
		bus(1'b1, CFG, 8'h07);
		commit();
		s0 = starts;
		repeat (40) @(posedge clk_sys_i);
		chk(32'(starts - s0 >= 5), 32'h1, "continuous");
		// A reset in mid-run drops the committed byte back to its reset value.
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		@(posedge clk_sys_i);
		rdchk(CFG, 32'h0000_0000, "mid-run reset");
		// Period zero stops automatic runs; a plain trigger runs without battery.
		bus(1'b1, CFG, 8'h00);
		commit();
		s0 = starts;
		repeat (200) @(posedge clk_sys_i);
		chk(32'(starts - s0), 32'h0, "period zero");
		bus(1'b1, TRIG, 8'h40);
		repeat (10) @(posedge clk_sys_i);
		chk(32'(starts - s0), 32'h1, "trigger again");
		chk({31'h0, bat_seen}, 32'h0, "no battery");
		$display("test period modes done");
		results();
	end
endmodule // tb_top

`default_nettype wire
